// ---- src/emsc_cfg.svh ----
// timing, field and reset constants for the enhanced-mode system control block
`ifndef EMSC_CFG_SVH
`define EMSC_CFG_SVH
`define EMSC_DIV_W          4
`define EMSC_DIV_RST        4'h1
`define EMSC_RFSH_W         16
`define EMSC_RFSH_RST       16'h0000
`define EMSC_ADDR_W         20
`define EMSC_QSEL_W         2
`define EMSC_MID2_QUARTER   2'h2
`define EMSC_CS_RST         4'hf
`define EMSC_STRAP_SETTLE   2'h2
`endif

// ---- src/emsc_pkg.sv ----
// types shared by the enhanced-mode system control block
package emsc_pkg;
    // test-mode tracking state, one-hot
    typedef enum logic [2:0] {
        EMSC_RUN    = 3'b001,
        EMSC_SAMPLE = 3'b010,
        EMSC_FLOAT  = 3'b100
    } emsc_tst_t;
    // chip-select decode request from the bus side
    typedef struct packed {
        logic        cycleValid;
        logic        refreshCycle;
        logic [19:0] address;
    } emsc_bus_t;
    // mid-range block window, programmed outside
    typedef struct packed {
        logic [19:0] base;
        logic [19:0] size;
        logic        programmed;
    } emsc_mid_t;
endpackage

// ---- src/emsc_clk_div.sv ----
// power-save divider producing the slowed tick and the clock-output level
`timescale 1ns/10ps
`include "emsc_cfg.svh"
module emsc_clk_div #(
    parameter int DIV_W = `EMSC_DIV_W
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // control
    input  wire logic             saveOn,   // divide active
    input  wire logic [DIV_W-1:0] divFactor, // divide ratio, 0 and 1 mean no slowing
    // results
    output logic                  tick,     // one-cycle enable at divided rate
    output logic                  clkLevel  // divided clock level
);
    logic [DIV_W-1:0] count_r;  // cycles since last tick
    logic             level_r;  // divided clock phase
    logic             slow;     // divider actually dividing

    initial begin
        if (DIV_W < 2) $error("divider width too small");
    end

    assign slow = saveOn && (divFactor > {{(DIV_W-1){1'b0}}, 1'b1});

    // count to the factor and fire one tick per period
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= '0;
        end else if (!slow || count_r >= divFactor - 1'b1) begin
            count_r <= '0;
        end else begin
            count_r <= count_r + 1'b1;
        end
    end

    // divided output: flips once per internal tick, so its period is two ticks at any factor
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            level_r <= 1'b0;
        end else if (!slow || count_r == '0) begin
            level_r <= ~level_r;  // undivided this flips every cycle, slowed it keeps the same ratio
        end
    end

    assign tick     = !slow || (count_r == '0);
    assign clkLevel = level_r;
endmodule // emsc_clk_div

// ---- src/emsc_top.sv ----
// enhanced-mode system control: refresh, power-save, coprocessor pins, float test mode
//
// Summary of operation
// RULE_01 - refresh runs only in enhanced mode
// RULE_02 - interval expiry raises refresh read request
// RULE_03 - refresh address in range asserts chip select
// RULE_04 - power-save divides internal clock by factor
// RULE_05 - clock output carries divided clock
// RULE_06 - all internal counting slows by factor
// RULE_07 - software reprograms counts around power-save
// RULE_08 - enhanced mode remaps selects 0,1,3
// RULE_09 - select 2 keeps normal ready/wait behaviour
// RULE_10 - select 2 only in its quarter
// RULE_11 - test mode floats all pins until reset
// RULE_12 - both memory selects low at release selects test
// RULE_13 - outside holds selects low one clock
// RULE_14 - memory select pins weakly pulled up
// RULE_15 - no coprocessor: reset output to busy input
// RULE_16 - compatible mode ignores enhanced writes
// RULE_17 - leaving power-save restores full clock
`timescale 1ns/10ps
`include "emsc_cfg.svh"
module emsc_top #(
    parameter int DIV_W  = `EMSC_DIV_W,
    parameter int RFSH_W = `EMSC_RFSH_W
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               reset_n,
    // mode strap and control
    input  wire logic               enhancedPin,     // enhanced-mode strap, from a pin
    input  wire logic               cfgWrite,        // write strobe for enhanced controls
    input  wire logic               saveReq,         // requested power-save
    input  wire logic [DIV_W-1:0]   divReq,          // requested divide factor
    input  wire logic               rfshEnReq,       // requested refresh enable
    input  wire logic [RFSH_W-1:0]  rfshIntervalReq, // requested refresh interval
    // bus interface unit
    input  wire logic               refreshAck,      // bus unit took the request
    input  wire emsc_pkg::emsc_bus_t busCycle,       // current bus cycle
    input  wire emsc_pkg::emsc_mid_t midBlock,       // mid-range window
    input  wire logic               extReady,        // external ready, for select 2
    // coprocessor side
    input  wire logic               coprocExtReqIn,  // extension request from coprocessor
    input  wire logic               coprocErrorIn,   // error from coprocessor
    // memory select pins (three-signal)
    input  wire logic               upperSelIn,      // upper_memory_select pin level
    input  wire logic               lowerSelIn,      // lower_memory_select pin level
    // outputs
    output logic                    refreshReq,      // memory read request to bus unit
    output logic                    clockOutPin,     // clock_output_pin level
    output logic                    internalTick,    // enable at internal rate
    output logic [3:0]              midSelect_n,     // mid-range selects, active low
    output logic                    midSelect2Ready, // ready for select 2 cycles
    output logic                    coprocExtReq,    // remapped coproc_extension_request
    output logic                    coprocError,     // remapped coprocessor error
    output logic                    numericProcSel_n,// numeric_proc_select, active low
    output logic                    pinFloat,        // all pins high impedance
    output logic                    pullUpEn,        // weak pull-up enable on memory selects
    output logic                    enhancedMode     // enhanced mode flag
);
    // synchronisers for pin inputs
    logic [1:0] enhSync_r, upSync_r, loSync_r, erSync_r, erqSync_r;
    // control state
    logic              enh_r;
    logic              save_r;
    logic [DIV_W-1:0]  div_r;
    logic              rfshEn_r;
    logic [RFSH_W-1:0] interval_r, rfshCnt_r;
    logic              refreshReq_r, clock_output_pin_r, tick_r;
    logic [3:0]        midSel_r;
    logic              mid2Rdy_r, coReq_r, coErr_r, nps_r, float_r, pull_r;
    logic              rfshPending_r;
    logic [1:0]        settleCnt_r;     // edges waited for the strap synchronisers
    emsc_pkg::emsc_tst_t tst_r;
    logic              tick, clkLevel;
    logic [1:0]        quarter;
    logic              inMid;

    initial begin
        if (RFSH_W < 2 || DIV_W < 2) $error("bad width parameter");
    end

    // decode which quarter of the mid-range block an address falls in
    function automatic logic [1:0] quarterOf(input logic [19:0] a, input logic [19:0] b, input logic [19:0] s);
        logic [19:0] off;
        off = a - b;
        quarterOf = (off >= (s >> 1)) ? ((off >= (s >> 1) + (s >> 2)) ? 2'h3 : 2'h2)
                                      : ((off >= (s >> 2)) ? 2'h1 : 2'h0);
    endfunction

    // two-flop synchronisers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            enhSync_r <= '0;
            upSync_r  <= 2'h3;
            loSync_r  <= 2'h3;
            erSync_r  <= '0;
            erqSync_r <= '0;
        end else begin
            enhSync_r <= {enhSync_r[0], enhancedPin};
            upSync_r  <= {upSync_r[0], upperSelIn};
            loSync_r  <= {loSync_r[0], lowerSelIn};
            erSync_r  <= {erSync_r[0], coprocErrorIn};
            erqSync_r <= {erqSync_r[0], coprocExtReqIn};
        end
    end

    // mode flag follows strap; enhanced-only controls written only when enhanced
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            enh_r      <= 1'b0;
            save_r     <= 1'b0;
            div_r      <= `EMSC_DIV_RST;
            rfshEn_r   <= 1'b0;
            interval_r <= `EMSC_RFSH_RST;
        end else begin
            enh_r <= enhSync_r[1];  // strap held by outside logic [RULE_15]
            if (!enh_r) begin
                save_r   <= 1'b0;  // features masked in compatible mode [RULE_04]
                rfshEn_r <= 1'b0;  // [RULE_01]
            end else if (cfgWrite) begin  // writes only take effect enhanced [RULE_16]
                save_r     <= saveReq;  // clearing restores full clock [RULE_17]
                div_r      <= divReq;
                rfshEn_r   <= rfshEnReq;
                interval_r <= rfshIntervalReq;  // software re-tunes on save change [RULE_07]
            end
        end
    end

    // power-save divider
    emsc_clk_div #(.DIV_W(DIV_W)) u_div (
        .clk       (clk),
        .reset_n   (reset_n),
        .saveOn    (save_r),     // [RULE_04]
        .divFactor (div_r),
        .tick      (tick),
        .clkLevel  (clkLevel)
    );

    // clock output and internal enable registered
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clock_output_pin_r <= 1'b0;
            tick_r   <= 1'b0;
        end else begin
            clock_output_pin_r <= clkLevel;  // divided when saving, full otherwise [RULE_05] [RULE_17]
            tick_r   <= tick;      // drives internalTick; the refresh counter uses the unregistered tick [RULE_06]
        end
    end

    // refresh interval counter advances only on internal ticks
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rfshCnt_r     <= '0;
            rfshPending_r <= 1'b0;
        end else if (!rfshEn_r || !enh_r) begin
            rfshCnt_r     <= '0;  // no refresh in compatible mode [RULE_01]
            rfshPending_r <= 1'b0;
        end else begin
            if (tick) begin  // slowed by power-save factor [RULE_06]
                if (rfshCnt_r >= interval_r) begin
                    rfshCnt_r <= '0;
                end else begin
                    rfshCnt_r <= rfshCnt_r + 1'b1;
                end
            end
            // expiry sets pending; new expiry wins over an ack [RULE_02]
            if (tick && rfshCnt_r >= interval_r) begin
                rfshPending_r <= 1'b1;
            end else if (refreshAck) begin
                rfshPending_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            refreshReq_r <= 1'b0;
        end else begin
            refreshReq_r <= rfshPending_r && !refreshAck;  // request to bus unit [RULE_02]
        end
    end

    // mid-range decode, refresh cycles included
    assign inMid   = midBlock.programmed && busCycle.cycleValid &&
                     busCycle.address >= midBlock.base &&
                     (busCycle.address - midBlock.base) < midBlock.size;
    assign quarter = quarterOf(busCycle.address, midBlock.base, midBlock.size);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            midSel_r  <= `EMSC_CS_RST;
            mid2Rdy_r <= 1'b0;
            nps_r     <= 1'b1;
        end else begin
            for (int i = 0; i < 4; i++) begin
                // refresh addresses decode like any other [RULE_03]
                midSel_r[i] <= !(inMid && quarter == i[1:0]);
            end
            if (enh_r) begin
                midSel_r[0] <= 1'b1;  // pins reused for coprocessor [RULE_08]
                midSel_r[1] <= 1'b1;
                midSel_r[3] <= 1'b1;
            end
            nps_r     <= !(enh_r && inMid && !busCycle.refreshCycle && quarter == 2'h3);  // [RULE_08]
            mid2Rdy_r <= inMid && quarter == `EMSC_MID2_QUARTER && extReady;  // [RULE_09] [RULE_10]
        end
    end

    // coprocessor handshake pins only in enhanced mode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            coReq_r <= 1'b0;
            coErr_r <= 1'b0;
        end else begin
            coReq_r <= enh_r && erqSync_r[1];  // [RULE_08]
            coErr_r <= enh_r && erSync_r[1];
        end
    end

    // test mode: sample straps after release, then float until reset if both selects were low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tst_r       <= emsc_pkg::EMSC_SAMPLE;
            float_r     <= 1'b0;
            pull_r      <= 1'b1;  // pull-ups on while reset applies [RULE_14]
            settleCnt_r <= 2'h0;
        end else begin
            case (tst_r)
                emsc_pkg::EMSC_SAMPLE: begin
                    if (settleCnt_r != `EMSC_STRAP_SETTLE) begin
                        // synchronisers still show their reset level; deciding now would never float
                        settleCnt_r <= settleCnt_r + 2'h1;
                    end else begin
                        pull_r <= 1'b0;
                        // both held low past release selects float [RULE_12] [RULE_13]
                        if (!upSync_r[1] && !loSync_r[1]) begin
                            tst_r   <= emsc_pkg::EMSC_FLOAT;
                            float_r <= 1'b1;
                        end else begin
                            tst_r <= emsc_pkg::EMSC_RUN;
                        end
                    end
                end
                emsc_pkg::EMSC_FLOAT: begin
                    float_r <= 1'b1;  // sticky until reset [RULE_11]
                end
                emsc_pkg::EMSC_RUN: begin
                    float_r <= 1'b0;
                end
                default: begin
                    tst_r <= emsc_pkg::EMSC_RUN;
                end
            endcase
        end
    end

    assign refreshReq       = refreshReq_r;
    assign clockOutPin      = clock_output_pin_r;
    assign internalTick     = tick_r;
    assign midSelect_n      = midSel_r;
    assign midSelect2Ready  = mid2Rdy_r;
    assign coprocExtReq     = coReq_r;
    assign coprocError      = coErr_r;
    assign numericProcSel_n = nps_r;
    assign pinFloat         = float_r;
    assign pullUpEn         = pull_r;
    assign enhancedMode     = enh_r;

    // float holds until reset
    float_hold_a: assert property (@(posedge clk) disable iff (!reset_n) float_r |=> float_r)  // [RULE_11]
        else $error("float mode left without reset");
    // no refresh request in compatible mode
    no_rfsh_compat_a: assert property (@(posedge clk) disable iff (!reset_n)
        !enh_r [*3] |-> !refreshReq_r)  // [RULE_01]
        else $error("refresh request in compatible mode");
    // select 2 only in its quarter
    mid2_quarter_a: assert property (@(posedge clk) disable iff (!reset_n)
        !midSel_r[2] |-> $past(inMid) && $past(quarter) == `EMSC_MID2_QUARTER)  // [RULE_10]
        else $error("select 2 outside its quarter");
    // remapped selects idle in enhanced mode
    remap_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
        $past(enh_r) |-> midSel_r[0] && midSel_r[1] && midSel_r[3])  // [RULE_08]
        else $error("remapped select driven in enhanced mode");
    // compatible writes ignored
    compat_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        !enh_r && cfgWrite |=> $stable(interval_r) && $stable(div_r))  // [RULE_16]
        else $error("write took effect in compatible mode");
    // full clock toggles when not saving
    full_clock_a: assert property (@(posedge clk) disable iff (!reset_n)
        !save_r [*3] |-> clock_output_pin_r != $past(clock_output_pin_r))  // [RULE_05] [RULE_17]
        else $error("clock output not full rate");
    // refresh count frozen between ticks
    slow_count_a: assert property (@(posedge clk) disable iff (!reset_n)
        rfshEn_r && enh_r && !tick |=> $stable(rfshCnt_r) || !rfshEn_r || !enh_r)  // [RULE_06]
        else $error("refresh count moved without tick");
    // expiry leads to request within two cycles
    rfsh_req_a: assert property (@(posedge clk) disable iff (!reset_n)
        enh_r && rfshEn_r && tick && rfshCnt_r >= interval_r && !refreshAck
        |-> ##[1:2] (refreshReq_r || refreshAck))  // [RULE_02]
        else $error("refresh expiry without request");
endmodule // emsc_top

// ---- bench/emsc_far_model.sv ----
// far-side model: bus unit acknowledging refresh reads, memory select pins with weak pull-ups
`timescale 1ns/10ps
module emsc_far_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // bench control
    input  wire logic [3:0] ackDelay,   // cycles the bus unit stalls before acknowledging
    input  wire logic       holdLow,    // test equipment drives both memory selects low
    // refresh handshake
    input  wire logic       refreshReq, // read request from the block
    output logic            refreshAck, // one-cycle acknowledge
    // memory select pin levels
    output logic            upperSelIn,
    output logic            lowerSelIn
);
    logic [3:0] waitCnt; // cycles the current request has been stalled
    // a released pin is pulled high, never left at its old level
    assign upperSelIn = holdLow ? 1'b0 : 1'b1;
    assign lowerSelIn = holdLow ? 1'b0 : 1'b1;
    // acknowledge after the chosen stall; one pulse, the request drops on the following edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            waitCnt    <= 4'h0;
            refreshAck <= 1'b0;
        end else if (refreshAck) begin
            refreshAck <= 1'b0; // old request is still visible here, so never ack twice
            waitCnt    <= 4'h0;
        end else if (refreshReq && waitCnt >= ackDelay) begin
            refreshAck <= 1'b1;
        end else if (refreshReq) begin
            waitCnt <= waitCnt + 4'h1;
        end
    end
endmodule // emsc_far_model

// ---- bench/emsc_top_bench.sv ----
// self-checking bench for the enhanced-mode system control block
`timescale 1ns/10ps
module emsc_top_bench;
    // stimulus
    logic                clk, reset_n, enhancedPin, cfgWrite, saveReq, rfshEnReq;
    logic                extReady, coprocExtReqIn, coprocErrorIn, holdLow;
    logic [3:0]          divReq, ackDelay;
    logic [15:0]         rfshIntervalReq;
    emsc_pkg::emsc_bus_t busCycle;
    emsc_pkg::emsc_mid_t midBlock;
    // observed
    logic                refreshReq, refreshAck, upperSelIn, lowerSelIn, clockOutPin, internalTick;
    logic                midSelect2Ready, coprocExtReq, coprocError, numericProcSel_n;
    logic                pinFloat, pullUpEn, enhancedMode;
    logic [3:0]          midSelect_n;
    int                  miscompares, samplesChecked, gap;

    emsc_top #(.DIV_W(4), .RFSH_W(16)) u_emsc_top (
        .clk, .reset_n, .enhancedPin, .cfgWrite, .saveReq, .divReq, .rfshEnReq, .rfshIntervalReq,
        .refreshAck, .busCycle, .midBlock, .extReady, .coprocExtReqIn, .coprocErrorIn,
        .upperSelIn, .lowerSelIn, .refreshReq, .clockOutPin, .internalTick, .midSelect_n,
        .midSelect2Ready, .coprocExtReq, .coprocError, .numericProcSel_n, .pinFloat,
        .pullUpEn, .enhancedMode);
    emsc_far_model u_emsc_far_model (
        .clk, .reset_n, .ackDelay, .holdLow, .refreshReq, .refreshAck, .upperSelIn, .lowerSelIn);

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // one comparison, four-state exact
    task automatic check(input logic [19:0] seen, input logic [19:0] expv);
        samplesChecked++;
        if (seen !== expv) begin
            miscompares++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, expv);
        end
    endtask

    // reset for 16 clocks; selects can be held low past release (sampled on the first clock, decided on the third)
    task automatic do_reset(input logic low);
        holdLow = low;
        reset_n = 1'b0;
        repeat (16) @(negedge clk);
        check(pullUpEn, 1'b1);
        check(midSelect_n, 4'hf);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        holdLow = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    // change the mode strap and let the synchroniser settle
    task automatic set_mode(input logic en);
        enhancedPin = en;
        repeat (6) @(negedge clk);
        check(enhancedMode, en);
    endtask

    // one write of the enhanced controls
    task automatic cfg_write(input logic save, input logic [3:0] dv, input logic en, input logic [15:0] iv);
        saveReq = save;
        divReq = dv;
        rfshEnReq = en;
        rfshIntervalReq = iv;
        cfgWrite = 1'b1;
        @(negedge clk);
        cfgWrite = 1'b0;
        repeat (8) @(negedge clk);
    endtask

    // clock-output toggles and internal ticks over a 48-cycle window
    task automatic rate(input int expToggles, input int expTicks);
        int   tg;
        int   tk;
        logic prev;
        tg = 0;
        tk = 0;
        prev = clockOutPin;
        repeat (48) begin
            @(negedge clk);
            if (clockOutPin !== prev) tg++;
            if (internalTick === 1'b1) tk++;
            prev = clockOutPin;
        end
        check(20'(tg), 20'(expToggles));
        check(20'(tk), 20'(expTicks));
    endtask

    // no refresh request may appear during the window
    task automatic no_rfsh(input int n);
        int c;
        c = 0;
        repeat (n) begin
            @(negedge clk);
            if (refreshReq !== 1'b0) c++;
        end
        check(20'(c), 20'h0);
    endtask

    // cycles from one request rise to the next, bounded
    task automatic rfsh_gap(output int g);
        g = 0;
        while (refreshReq !== 1'b0 && g < 300) begin @(negedge clk); g++; end
        while (refreshReq !== 1'b1 && g < 300) begin @(negedge clk); g++; end
        g = 0;
        while (refreshReq === 1'b1 && g < 300) begin @(negedge clk); g++; end
        while (refreshReq !== 1'b1 && g < 300) begin @(negedge clk); g++; end
    endtask

    // one bus cycle into the mid-range window, selects checked once settled
    task automatic decode(input int q, input logic rf, input logic [3:0] expSel, input logic expNps);
        busCycle = '{cycleValid: 1'b1, refreshCycle: rf, address: 20'h80010 + 20'(q) * 20'h04000};
        repeat (3) @(negedge clk);
        check(midSelect_n, expSel);
        check(numericProcSel_n, expNps);
        check(midSelect2Ready, (q == 2) && extReady);
        busCycle.cycleValid = 1'b0;
        @(negedge clk);
    endtask

    // verdict, the single end of the run
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // watchdog at 20000 cycles, well beyond the roughly one thousand cycles expected
    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end

    // main sequence
    initial begin
        {reset_n, enhancedPin, cfgWrite, saveReq, rfshEnReq, coprocExtReqIn, coprocErrorIn, holdLow} = '0;
        {divReq, rfshIntervalReq, busCycle} = '0;
        extReady = 1'b1;
        ackDelay = 4'h0;
        midBlock = '{base: 20'h80000, size: 20'h10000, programmed: 1'b1};
        do_reset(1'b0);
        check(pinFloat, 1'b0);
        // compatible mode: enhanced writes refused, no refresh, no slowing
        cfg_write(1'b1, 4'h4, 1'b1, 16'h0003);
        rate(48, 48);
        no_rfsh(60);
        for (int q = 0; q < 4; q++) decode(q, 1'b0, ~(4'h1 << q), 1'b1);
        // enhanced mode: the earlier write must not have armed refresh
        set_mode(1'b1);
        no_rfsh(60);
        for (int q = 0; q < 3; q++) decode(q, 1'b0, (q == 2) ? 4'hb : 4'hf, 1'b1);
        decode(3, 1'b0, 4'hf, 1'b0);
        decode(2, 1'b1, 4'hb, 1'b1);
        extReady = 1'b0;
        decode(2, 1'b0, 4'hb, 1'b1);
        extReady = 1'b1;
        for (int v = 1; v >= 0; v--) begin
            coprocExtReqIn = v[0];
            coprocErrorIn = v[0];
            repeat (5) @(negedge clk);
            check(coprocExtReq, v[0]);
            check(coprocError, v[0]);
        end
        // refresh every interval+1 ticks, slowed by the divide factor in power-save
        cfg_write(1'b0, 4'h1, 1'b1, 16'h0020);
        rfsh_gap(gap);
        check(20'(gap), 20'd33);
        cfg_write(1'b1, 4'h2, 1'b1, 16'h0020);
        rfsh_gap(gap);
        check(20'(gap), 20'd66);
        cfg_write(1'b1, 4'h2, 1'b1, 16'h000f);
        rfsh_gap(gap);
        check(20'(gap), 20'd32);
        rate(24, 24);
        cfg_write(1'b1, 4'h4, 1'b1, 16'h0020);
        rate(12, 12);
        cfg_write(1'b0, 4'h4, 1'b1, 16'h0020);
        rate(48, 48);
        // slow bus unit: the request stands until acknowledged
        ackDelay = 4'h8;
        rfsh_gap(gap);
        repeat (5) @(negedge clk);
        check(refreshReq, 1'b1);
        repeat (8) @(negedge clk);
        check(refreshReq, 1'b0);
        // back to compatible: refresh stops
        set_mode(1'b0);
        no_rfsh(80);
        // float test mode: entered by low selects at release, sticky until reset
        do_reset(1'b1);
        check(pinFloat, 1'b1);
        repeat (50) @(negedge clk);
        check(pinFloat, 1'b1);
        do_reset(1'b0);
        check(pinFloat, 1'b0);
        print_verdict();
    end
endmodule // emsc_top_bench
